// ### common/ssgl_pkg.sv
// Constants, register map and carrier types of the serial gain code loader
package ssgl_pkg;
    localparam int CODE_W = 6;
    localparam logic [5:0] CODE_MIN = 6'h01;
    localparam logic [5:0] CODE_MAX = 6'h3C;
    localparam logic [5:0] CODE_RST = 6'h01;
    // Gain in half dB units at code zero; each code adds two half dB
    localparam int GAIN_BASE_HALF_DB = -53;
    localparam int GAIN_STEP_HALF_DB = 2;
    localparam logic [7:0] GAIN_OFFSET = 8'(GAIN_BASE_HALF_DB);
    localparam logic [7:0] GAIN_RST = 8'(GAIN_BASE_HALF_DB + GAIN_STEP_HALF_DB);
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_GAIN = 8'h08;
    localparam logic [7:0] OFS_LOADS = 8'h0C;
    localparam int STS_CODE_LSB = 0;
    localparam int STS_SHIFT_LSB = 8;
    localparam int STS_ENABLE_BIT = 16;
    localparam int STS_AWAKE_BIT = 17;
    localparam int STS_WINDOW_BIT = 18;
    localparam int STS_DONE_BIT = 24;
    localparam int CTL_PORT_EN_BIT = 0;
    localparam logic CTL_PORT_EN_RST = 1'b1;
    localparam int LOADS_W = 16;

    typedef struct packed {
        logic serial_clk;
        logic load_window_n;
        logic serial_gain_in;
        logic transmit_on;
        logic sleep_n;
    } ssgl_pins_t;

    localparam ssgl_pins_t PINS_RST = '{serial_clk: 1'b0, load_window_n: 1'b1,
        serial_gain_in: 1'b0, transmit_on: 1'b0, sleep_n: 1'b1};

    typedef struct packed {
        logic enable;
        logic awake;
    } ssgl_amp_t;

    localparam ssgl_amp_t AMP_RST = '{enable: 1'b0, awake: 1'b1};
endpackage

// ### design/ssgl_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module ssgl_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ### design/ssgl_top.sv
// Serial gain code loader with amplifier enable and sleep control
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module ssgl_top (
    input wire logic clock,
    input wire logic rst,
    input wire ssgl_pkg::ssgl_pins_t pins,
    input wire logic [ssgl_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [ssgl_pkg::CODE_W-1:0] applied_code,
    output logic [7:0] gain_half_db,
    output ssgl_pkg::ssgl_amp_t amp
);
    import ssgl_pkg::*;

    ssgl_pins_t pins_s;
    logic sclk_d_reg;
    logic window_d_reg;
    logic [CODE_W-1:0] shift_reg;
    logic port_en_reg;
    logic done_reg;
    logic [LOADS_W-1:0] loads_reg;
    logic sclk_rise;
    logic window_rise;
    logic apply_load;
    logic bus_write;
    logic [31:0] read_next;

    function automatic logic [CODE_W-1:0] sat_code(input logic [CODE_W-1:0] c);
        if (c > CODE_MAX) begin
            sat_code = CODE_MAX;
        end else if (c < CODE_MIN) begin
            sat_code = CODE_MIN;
        end else begin
            sat_code = c;
        end
    endfunction

    // Pins come from the host's domain, so all of them are synchronised first
    ssgl_sync #(
        .WIDTH($bits(ssgl_pins_t)),
        .RST_VAL(PINS_RST)
    ) u_pin_sync (
        .clock(clock),
        .rst(rst),
        .d(pins),
        .q(pins_s)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sclk_d_reg <= PINS_RST.serial_clk;
            window_d_reg <= PINS_RST.load_window_n;
        end else begin
            sclk_d_reg <= pins_s.serial_clk;
            window_d_reg <= pins_s.load_window_n;
        end
    end

    assign sclk_rise = pins_s.serial_clk && !sclk_d_reg;
    assign window_rise = pins_s.load_window_n && !window_d_reg;
    assign apply_load = window_rise && port_en_reg;

    // Shift only while the window is open; older bits fall off the top
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shift_reg <= '0;
        end else if (sclk_rise && !pins_s.load_window_n) begin
            shift_reg <= {shift_reg[CODE_W-2:0], pins_s.serial_gain_in};
        end
    end

    // Applied code changes only on the window's rising edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            applied_code <= CODE_RST;
        end else if (apply_load) begin
            applied_code <= sat_code(shift_reg);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gain_half_db <= GAIN_RST;
        end else begin
            gain_half_db <= {1'b0, applied_code, 1'b0} + GAIN_OFFSET;
        end
    end

    // Two-clock synchroniser delay is the price of a clean sampled domain
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            amp <= AMP_RST;
        end else begin
            amp.enable <= pins_s.transmit_on;
            amp.awake <= pins_s.sleep_n;
        end
    end

    assign bus_write = write && !waitrequest;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            port_en_reg <= CTL_PORT_EN_RST;
        end else if (bus_write && address == OFS_CONTROL) begin
            port_en_reg <= writedata[CTL_PORT_EN_BIT];
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done_reg <= 1'b0;
        end else if (apply_load) begin
            done_reg <= 1'b1;
        end else if (bus_write && address == OFS_STATUS && writedata[STS_DONE_BIT]) begin
            done_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            loads_reg <= '0;
        end else if (apply_load) begin
            loads_reg <= loads_reg + 1'b1;
        end
    end

    always_comb begin
        read_next = 32'h00000000;
        case (address)
            OFS_STATUS: begin
                read_next[STS_CODE_LSB +: CODE_W] = applied_code;
                read_next[STS_SHIFT_LSB +: CODE_W] = shift_reg;
                read_next[STS_ENABLE_BIT] = amp.enable;
                read_next[STS_AWAKE_BIT] = amp.awake;
                read_next[STS_WINDOW_BIT] = !pins_s.load_window_n;
                read_next[STS_DONE_BIT] = done_reg;
            end
            OFS_CONTROL: begin
                read_next[CTL_PORT_EN_BIT] = port_en_reg;
            end
            OFS_GAIN: begin
                read_next[7:0] = gain_half_db;
            end
            OFS_LOADS: begin
                read_next[LOADS_W-1:0] = loads_reg;
            end
            default: begin
                read_next = 32'h00000000;
            end
        endcase
    end

    // One wait cycle per access keeps readdata a plain register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
            readdata <= read_next;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    AST_SHIFT_IN: assert property (@(posedge clock) disable iff (rst)
        (sclk_rise && !pins_s.load_window_n) |=>
        shift_reg == {$past(shift_reg[CODE_W-2:0]), $past(pins_s.serial_gain_in)})
        else $error("Shift register did not take the sampled bit");

    AST_SHIFT_CLOSED: assert property (@(posedge clock) disable iff (rst)
        pins_s.load_window_n |=> $stable(shift_reg))
        else $error("Shift register moved while the window was closed");

    AST_APPLY: assert property (@(posedge clock) disable iff (rst)
        (window_rise && port_en_reg) |=> applied_code == sat_code($past(shift_reg)))
        else $error("Window rise did not apply the shifted code");

    AST_HOLD_GAIN: assert property (@(posedge clock) disable iff (rst)
        !apply_load |=> $stable(applied_code))
        else $error("Applied code changed without a load");

    AST_RANGE: assert property (@(posedge clock) disable iff (rst)
        applied_code >= CODE_MIN && applied_code <= CODE_MAX)
        else $error("Applied code outside one to sixty");

    AST_GAIN_MAP: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> $signed(gain_half_db) ==
        GAIN_STEP_HALF_DB * int'($past(applied_code)) + GAIN_BASE_HALF_DB)
        else $error("Gain does not follow the code");

    AST_POWER_UP: assert property (@(posedge clock) disable iff (rst)
        $past(rst) |-> applied_code == CODE_MIN)
        else $error("Code after reset is not the minimum");

    AST_TRANSMIT_OFF: assert property (@(posedge clock) disable iff (rst)
        (!pins.transmit_on) [*4] |=> !amp.enable)
        else $error("Amplifier still enabled with transmit low");

    AST_SLEEP_ON: assert property (@(posedge clock) disable iff (rst)
        (!pins.sleep_n) [*4] |=> !amp.awake)
        else $error("Amplifier not asleep with sleep low");

    AST_WAKE: assert property (@(posedge clock) disable iff (rst)
        pins.sleep_n [*4] |=> amp.awake)
        else $error("Amplifier not awake with sleep high");

    AST_BUS_ONE_WAIT: assert property (@(posedge clock) disable iff (rst)
        ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
        else $error("Bus answer not one cycle after request");
endmodule

// ### test/ssgl_host.sv
// Host controller model driving the serial gain and amplifier pins
`timescale 1ns/1ps
module ssgl_host (
    input wire logic clock,
    output ssgl_pkg::ssgl_pins_t pins
);
    import ssgl_pkg::*;
    initial pins = PINS_RST;
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Link clock of 8 clocks (400 ns), still and low outside frames
    task automatic frame(input logic [7:0] word, input int nbits, input logic hold_high);
        tick(1);
        pins.load_window_n <= hold_high;
        for (int i = nbits - 1; i >= 0; i--) begin
            pins.serial_gain_in <= word[i];
            tick(4);
            pins.serial_clk <= 1'b1;
            tick(4);
            pins.serial_clk <= 1'b0;
        end
        tick(4);
        pins.load_window_n <= 1'b1;
        // Released data line shows a changed level, not the last bit
        pins.serial_gain_in <= ~pins.serial_gain_in;
    endtask
    task automatic amp_ctl(input logic tx, input logic awake);
        tick(1);
        pins.transmit_on <= tx;
        pins.sleep_n <= awake;
    endtask
endmodule

// ### test/tb_serial_gain_code_loader.sv
// Self-checking bench of the serial gain code loader
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_serial_gain_code_loader;
    import ssgl_pkg::*;
    typedef struct {logic [7:0] word; int nbits; logic [5:0] code;} ssgl_row_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    ssgl_pins_t pins;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = '0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [CODE_W-1:0] applied_code;
    logic [7:0] gain_half_db;
    ssgl_amp_t amp;
    int num_errors = 0;
    int num_checks = 0;
    logic [31:0] rd;
    ssgl_row_t rows [9] = '{'{8'h01, 6, 6'h01}, '{8'h3C, 6, 6'h3C}, '{8'h3D, 6, 6'h3C},
        '{8'h3E, 6, 6'h3C}, '{8'h3F, 6, 6'h3C}, '{8'h4B, 8, 6'h0B}, '{8'hDE, 8, 6'h1E},
        '{8'h2A, 6, 6'h2A}, '{8'h00, 6, 6'h01}};
    always #25 clock = ~clock;
    ssgl_top DUT (.clock(clock), .rst(rst), .pins(pins), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .applied_code(applied_code),
        .gain_half_db(gain_half_db), .amp(amp));
    ssgl_host host (.clock(clock), .pins(pins));
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rdv);
        int n;
        @(posedge clock);
        address <= a;
        writedata <= wd;
        read <= ~wr;
        write <= wr;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            num_errors++;
            conclude();
        end
        rdv = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // Latency is fixed by the synchronisers: three clocks to code, one more to gain
    task automatic load(input logic [7:0] w, input int nb, input logic [5:0] c);
        host.frame(w, nb, 1'b0);
        repeat (8) @(posedge clock);
        `CHK(applied_code, c)
        `CHK(gain_half_db, 8'(2 * int'(c) - 53))
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        `CHK(applied_code, 6'h01)
        `CHK(gain_half_db, 8'hCD)
        `CHK(amp, AMP_RST)
        bus(1'b0, 8'h10, '0, rd);
        `CHK(rd, 32'h0)
        bus(1'b0, OFS_CONTROL, '0, rd);
        `CHK(rd[0], 1'b1)
        $display("reset test done");
        foreach (rows[i]) begin
            load(rows[i].word, rows[i].nbits, rows[i].code);
            bus(1'b0, OFS_STATUS, '0, rd);
            `CHK(rd[5:0], rows[i].code)
        end
        $display("row test done");
        host.frame(8'h15, 6, 1'b1);
        load(8'h00, 0, 6'h01);
        load(8'h0A, 6, 6'h0A);
        load(8'h07, 3, 6'h17);
        $display("window test done");
        bus(1'b1, OFS_CONTROL, 32'h0, rd);
        load(8'h14, 6, 6'h17);
        bus(1'b1, OFS_CONTROL, 32'h1, rd);
        load(8'h00, 0, 6'h14);
        // Status shows code, shift register, awake and a set load flag
        bus(1'b0, OFS_STATUS, '0, rd);
        `CHK(rd, 32'h0102_1414)
        bus(1'b0, OFS_GAIN, '0, rd);
        `CHK(rd, 32'h0000_00F3)
        // Nine rows, three window loads and one enabled load; the disabled one is lost
        bus(1'b0, OFS_LOADS, '0, rd);
        `CHK(rd, 32'h0000_000D)
        bus(1'b1, OFS_STATUS, 32'h0100_0000, rd);
        bus(1'b0, OFS_STATUS, '0, rd);
        `CHK(rd[24], 1'b0)
        $display("control test done");
        host.amp_ctl(1'b1, 1'b1);
        repeat (5) @(posedge clock);
        `CHK(amp, 2'b11)
        bus(1'b0, OFS_STATUS, '0, rd);
        `CHK(rd[17:16], 2'b11)
        host.amp_ctl(1'b0, 1'b0);
        repeat (5) @(posedge clock);
        `CHK(amp, 2'b00)
        host.amp_ctl(1'b1, 1'b1);
        repeat (5) @(posedge clock);
        `CHK(amp.awake, 1'b1)
        $display("amplifier test done");
        // Reset in mid-run must bring back the power-up state
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        `CHK(applied_code, 6'h01)
        `CHK(gain_half_db, 8'hCD)
        `CHK(amp, AMP_RST)
        bus(1'b0, OFS_LOADS, '0, rd);
        `CHK(rd, 32'h0)
        load(8'h25, 6, 6'h25);
        $display("mid-run reset test done");
        conclude();
    end
endmodule
